// ===== gp_pkg.sv
// Constants, register map and variant type for the 8-bit GPIO port.
// Assumes an APB3 slave context with 32-bit data and a single 10 MHz clock.
//
// What this block does
// [R1] Drive output data onto output-direction pins
// [R2] Direction writes never alter output data
// [R3] Output data resets zero or ones by variant
// [R4] Input register reads live pin levels
// [R5] Direction one drives pin; resets to input
// [R6] Direction zero tri-states pin, plain variants
// [R7] Pull-up when input and output bit one
// [R8] Merged variant: pull-up plus edge interrupts
// [R9] Six-irq: bit 7 polarity for two-five
// [R10] Six-irq: bit 6 polarity for zero-one
// [R11] Six-irq: bits 5..0 enable each interrupt
// [R12] Six-irq: flag bits 7,6 read zero
// [R13] Flag set on edge, held until cleared
// [R14] Software setting a flag raises interrupt
// [R15] Eight-irq: bits 7..0 enable each interrupt
// [R16] Eight-irq: per-pin edge select, resets rising
// [R17] Eight-irq: all eight flags read/write
// [R18] Synchronise pins, one flag per edge
// [R19] Interrupt high while flag and enable
package gp_pkg;

  // Port variants: A six irqs, B plain, C pull-up, D pull-up with eight irqs
  typedef enum {GP_TYPE_A, GP_TYPE_B, GP_TYPE_C, GP_TYPE_D} gp_variant_e;

  localparam int GP_PINS   = 8;
  localparam int GP_ADDR_W = 8;
  localparam int GP_DATA_W = 32;

  // Register byte offsets
  localparam logic [GP_ADDR_W-1:0] GP_OFF_OUT   = 8'h00;
  localparam logic [GP_ADDR_W-1:0] GP_OFF_IN    = 8'h04;
  localparam logic [GP_ADDR_W-1:0] GP_OFF_DIR   = 8'h08;
  localparam logic [GP_ADDR_W-1:0] GP_OFF_IEN   = 8'h0c;
  localparam logic [GP_ADDR_W-1:0] GP_OFF_IFLAG = 8'h10;
  localparam logic [GP_ADDR_W-1:0] GP_OFF_IEDGE = 8'h14;

  // Reset values
  localparam logic [GP_PINS-1:0] GP_OUT_RST_LOW  = 8'h00;
  localparam logic [GP_PINS-1:0] GP_OUT_RST_HIGH = 8'hff;
  localparam logic [GP_PINS-1:0] GP_DIR_RST      = 8'h00;
  localparam logic [GP_PINS-1:0] GP_IEN_RST      = 8'h00;
  localparam logic [GP_PINS-1:0] GP_IFLAG_RST    = 8'h00;
  localparam logic [GP_PINS-1:0] GP_IEDGE_RST    = 8'h00;

  // Six-interrupt layout: enables in 5..0, group polarity in 7 and 6
  localparam logic [GP_PINS-1:0] GP_A_IRQ_MASK = 8'h3f;
  localparam int                 GP_A_POL_HI   = 7;
  localparam int                 GP_A_POL_LO   = 6;
  localparam int                 GP_A_GRP_HI   = 2;
  localparam logic [GP_PINS-1:0] GP_D_IRQ_MASK = 8'hff;
  localparam logic [GP_PINS-1:0] GP_NO_IRQ     = 8'h00;

endpackage : gp_pkg

// ===== gp_edge_det.sv
// Two-flop synchroniser and edge detector for a group of pins.
// Assumes pins may change at any time; one pulse per transition.
`timescale 1ns/100ps
module gp_edge_det
  import gp_pkg::*;
#(
  parameter int W = GP_PINS
)
(
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Pin levels and edge pulses
  input  wire logic [W-1:0] pin_lvl,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] sync1_r;
  logic [W-1:0] sync2_r;
  logic [W-1:0] prev_r;
  logic [W-1:0] sync1_nxt;
  logic [W-1:0] sync2_nxt;
  logic [W-1:0] prev_nxt;

  // Shift chain; the second and third stages feed the comparison
  always_comb
  begin
    sync1_nxt = pin_lvl;
    sync2_nxt = sync1_r;
    prev_nxt  = sync2_r;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r  <= '0;
    end
    else
    begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      prev_r  <= prev_nxt;
    end
  end

  // Compare consecutive settled samples
  assign rise = sync2_r & ~prev_r; // R18
  assign fall = ~sync2_r & prev_r; // R18

endmodule : gp_edge_det

// ===== gp_port.sv
// Top of the 8-bit GPIO port with optional pull-ups and edge interrupts.
// Assumes an APB3 master, pin inputs synchronous to pclk, and an external
// pad that resolves pin_out, pin_oe_n and pullup_en into the wire level.
`timescale 1ns/100ps
module gp_port
  import gp_pkg::*;
#(
  parameter gp_variant_e VARIANT = GP_TYPE_D
)
(
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [GP_ADDR_W-1:0] paddr,
  input  wire logic [GP_DATA_W-1:0] pwdata,
  output logic      [GP_DATA_W-1:0] prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Port pins
  input  wire logic [GP_PINS-1:0]   pin_in,
  output logic      [GP_PINS-1:0]   pin_out,
  output logic      [GP_PINS-1:0]   pin_oe_n,
  output logic      [GP_PINS-1:0]   pullup_en,
  // Interrupt request
  output logic                      irq
);

  // Variant-dependent features
  localparam logic HAS_PU  = (VARIANT == GP_TYPE_C) || (VARIANT == GP_TYPE_D);
  localparam logic HAS_A   = (VARIANT == GP_TYPE_A);
  localparam logic HAS_D   = (VARIANT == GP_TYPE_D);
  localparam logic HAS_IRQ = HAS_A || HAS_D;
  localparam logic [GP_PINS-1:0] OUT_RST   = HAS_PU ? GP_OUT_RST_HIGH : GP_OUT_RST_LOW; // R3
  localparam logic [GP_PINS-1:0] FLAG_MASK = HAS_D ? GP_D_IRQ_MASK :
                                             (HAS_A ? GP_A_IRQ_MASK : GP_NO_IRQ);

  // Register state
  logic [GP_PINS-1:0]   out_r;
  logic [GP_PINS-1:0]   dir_r;
  logic [GP_PINS-1:0]   ien_r;
  logic [GP_PINS-1:0]   flag_r;
  logic [GP_PINS-1:0]   edge_r;
  logic [GP_PINS-1:0]   out_nxt;
  logic [GP_PINS-1:0]   dir_nxt;
  logic [GP_PINS-1:0]   ien_nxt;
  logic [GP_PINS-1:0]   flag_nxt;
  logic [GP_PINS-1:0]   edge_nxt;

  // Pin and interrupt output registers
  logic [GP_PINS-1:0]   oe_n_r;
  logic [GP_PINS-1:0]   pu_r;
  logic                 irq_r;
  logic [GP_PINS-1:0]   oe_n_nxt;
  logic [GP_PINS-1:0]   pu_nxt;
  logic                 irq_nxt;

  // APB answer registers
  logic [GP_DATA_W-1:0] prdata_r;
  logic                 pready_r;
  logic                 pslverr_r;
  logic [GP_DATA_W-1:0] prdata_nxt;
  logic                 pready_nxt;
  logic                 pslverr_nxt;

  // Decode and edge terms
  logic [GP_PINS-1:0]   rd_val;
  logic                 addr_ok;
  logic                 wr_en;
  logic                 wr_out;
  logic                 wr_dir;
  logic                 wr_ien;
  logic                 wr_flag;
  logic                 wr_edge;
  logic [GP_PINS-1:0]   wbyte;
  logic [GP_PINS-1:0]   rise;
  logic [GP_PINS-1:0]   fall;
  logic [GP_PINS-1:0]   pol_fall;
  logic [GP_PINS-1:0]   hw_set;
  logic [GP_PINS-1:0]   irq_mask;

  // Edge detection on all eight pins; FLAG_MASK keeps only the interrupt-capable ones
  gp_edge_det #(
    .W       (GP_PINS)
  ) u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_lvl (pin_in),
    .rise    (rise),
    .fall    (fall)
  );

  // Address decode and read mux; missing registers of a variant are unmapped
  always_comb
  begin
    addr_ok = 1'b1;
    rd_val  = '0;
    case (paddr)
      GP_OFF_OUT:   rd_val = out_r;
      GP_OFF_IN:    rd_val = pin_in;             // R4
      GP_OFF_DIR:   rd_val = dir_r;
      GP_OFF_IEN:
      begin
        addr_ok = HAS_IRQ;
        rd_val  = HAS_IRQ ? ien_r : '0;
      end
      GP_OFF_IFLAG:
      begin
        addr_ok = HAS_IRQ;
        rd_val  = flag_r & FLAG_MASK;            // R12
      end
      GP_OFF_IEDGE:
      begin
        addr_ok = HAS_D;
        rd_val  = HAS_D ? edge_r : '0;
      end
      default:
      begin
        addr_ok = 1'b0;
        rd_val  = '0;
      end
    endcase
  end

  // Write strobes, taken at the access edge with pready high
  always_comb
  begin
    wr_en   = psel && penable && pready_r && pwrite && addr_ok;
    wbyte   = pwdata[GP_PINS-1:0];
    wr_out  = wr_en && (paddr == GP_OFF_OUT);
    wr_dir  = wr_en && (paddr == GP_OFF_DIR);
    wr_ien  = wr_en && (paddr == GP_OFF_IEN);
    wr_flag = wr_en && (paddr == GP_OFF_IFLAG);
    wr_edge = wr_en && (paddr == GP_OFF_IEDGE);
  end

  // Edge polarity and enable mask per variant
  always_comb
  begin
    pol_fall = '0;
    irq_mask = '0;
    for (int i = 0; i < GP_PINS; i++)
    begin
      if (HAS_D)
      begin
        pol_fall[i] = edge_r[i];                 // R16
      end
      else if (HAS_A)
      begin
        if (i >= GP_A_GRP_HI)
        begin
          pol_fall[i] = ien_r[GP_A_POL_HI];      // R9
        end
        else
        begin
          pol_fall[i] = ien_r[GP_A_POL_LO];      // R10
        end
      end
    end
    if (HAS_D)
    begin
      irq_mask = ien_r;                          // R15
    end
    else if (HAS_A)
    begin
      irq_mask = ien_r & GP_A_IRQ_MASK;          // R11
    end
    hw_set = ((rise & ~pol_fall) | (fall & pol_fall)) & FLAG_MASK; // R17 R18
  end

  // Register next values
  always_comb
  begin
    out_nxt  = wr_out  ? wbyte : out_r;          // R1
    dir_nxt  = wr_dir  ? wbyte : dir_r;          // R2
    ien_nxt  = (wr_ien && HAS_IRQ) ? wbyte : ien_r;
    edge_nxt = (wr_edge && HAS_D) ? wbyte : edge_r;
    // Software may set or clear; a hardware edge in the same cycle wins
    flag_nxt = wr_flag ? (wbyte & FLAG_MASK) : flag_r; // R13 R14
    flag_nxt = flag_nxt | hw_set;                // R13
  end

  // Pin drive and pull-up computed from next state; interrupt from current flags and enables
  always_comb
  begin
    oe_n_nxt = ~dir_nxt;                         // R5 R6
    pu_nxt   = HAS_PU ? (~dir_nxt & out_nxt) : '0; // R7 R8
    irq_nxt  = |(flag_r & irq_mask);             // R19
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_r  <= OUT_RST;                         // R3
      dir_r  <= GP_DIR_RST;                      // R5
      ien_r  <= GP_IEN_RST;
      flag_r <= GP_IFLAG_RST;
      edge_r <= GP_IEDGE_RST;                    // R16
      oe_n_r <= ~GP_DIR_RST;
      pu_r   <= HAS_PU ? (~GP_DIR_RST & OUT_RST) : '0;
      irq_r  <= 1'b0;
    end
    else
    begin
      out_r  <= out_nxt;
      dir_r  <= dir_nxt;
      ien_r  <= ien_nxt;
      flag_r <= flag_nxt;
      edge_r <= edge_nxt;
      oe_n_r <= oe_n_nxt;
      pu_r   <= pu_nxt;
      irq_r  <= irq_nxt;
    end
  end

  // APB answer: data and ready prepared in setup, one access cycle each
  always_comb
  begin
    pready_nxt  = psel && !penable;
    pslverr_nxt = psel && !penable && !addr_ok;
    prdata_nxt  = prdata_r;
    if (psel && !penable)
    begin
      prdata_nxt = (!pwrite && addr_ok) ? {{(GP_DATA_W-GP_PINS){1'b0}}, rd_val} : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Outputs straight from flops
  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign pin_out   = out_r;
  assign pin_oe_n  = oe_n_r;
  assign pullup_en = pu_r;
  assign irq       = irq_r;

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  out_keep_a: assert property (wr_dir |=> $stable(out_r)) // R2
    else $error("Direction write changed output data");

  pin_drive_a: assert property (pin_oe_n == ~dir_r && pin_out == out_r) // R1
    else $error("Pin drive does not follow direction and data");

  pullup_ctl_a: assert property (pullup_en == (HAS_PU ? (~dir_r & out_r) : 8'h00)) // R7
    else $error("Pull-up enable wrong");

  input_read_a: assert property ((psel && !penable && !pwrite && paddr == GP_OFF_IN)
                                 |=> prdata[GP_PINS-1:0] == $past(pin_in) && pready) // R4
    else $error("Input read does not return pin levels");

  flag_set_a: assert property ((|hw_set) |=> ((flag_r & $past(hw_set)) == $past(hw_set))) // R13
    else $error("Detected edge did not set its flag");

  flag_hold_a: assert property ((!wr_flag) |=> ((flag_r & $past(flag_r)) == $past(flag_r))) // R13
    else $error("Flag dropped without a software write");

  sw_set_a: assert property ((wr_flag && |(wbyte & irq_mask & FLAG_MASK))
                             |=> ##1 irq) // R14
    else $error("Software-set enabled flag raised no interrupt");

  irq_level_a: assert property (1'b1 |=> irq == $past(|(flag_r & irq_mask))) // R19
    else $error("Interrupt level does not match flags and enables");

  rsvd_zero_a: assert property ((flag_r & ~FLAG_MASK) == 8'h00) // R12
    else $error("Reserved flag bit set");

  edge_once_a: assert property ((hw_set != 8'h00) |=> ((hw_set & $past(hw_set)) == 8'h00)) // R18
    else $error("One transition flagged twice");

  a_group_pol_a: assert property (HAS_A |-> pol_fall[GP_A_GRP_HI] == ien_r[GP_A_POL_HI]
                                  && pol_fall[0] == ien_r[GP_A_POL_LO]) // R9
    else $error("Group polarity mapping wrong");

  access_ready_a: assert property ((psel && !penable) |=> pready ##1 !pready) // R4
    else $error("APB ready timing wrong");

endmodule : gp_port

// ===== gp_pin_model.sv
// Model of the pads and outside sources on the eight port pins.
// Assumes one clock; a pin nobody drives shows the inverse of its last driven level.
`timescale 1ns/100ps
module gp_pin_model
  import gp_pkg::*;
(
  // Clock
  input  wire logic               pclk,
  // Port side
  input  wire logic [GP_PINS-1:0] pin_out,
  input  wire logic [GP_PINS-1:0] pin_oe_n,
  input  wire logic [GP_PINS-1:0] pullup_en,
  // Outside sources
  input  wire logic [GP_PINS-1:0] ext_drv,
  input  wire logic [GP_PINS-1:0] ext_en,
  output logic      [GP_PINS-1:0] pin_lvl
);
  logic [GP_PINS-1:0] last_r = 8'h00;

  // Last driven level; a floating pin settles to its inverse instead of toggling
  always_ff @(posedge pclk)
  begin
    for (int i = 0; i < GP_PINS; i++)
    begin
      if (!pin_oe_n[i] || ext_en[i] || pullup_en[i])
      begin
        last_r[i] <= pin_lvl[i];
      end
    end
  end

  // Port drive first, then outside source, then pull-up
  always_comb
  begin
    for (int i = 0; i < GP_PINS; i++)
    begin
      if (!pin_oe_n[i])
        pin_lvl[i] = pin_out[i];
      else if (ext_en[i])
        pin_lvl[i] = ext_drv[i];
      else if (pullup_en[i])
        pin_lvl[i] = 1'b1;
      else
        pin_lvl[i] = ~last_r[i];
    end
  end
endmodule : gp_pin_model

// ===== gp_port_bench.sv
// Self-checking bench for the GPIO port, merged and six-interrupt variants on one bus.
// Assumes the pin model resolves the wire level fed back to pin_in.
`timescale 1ns/100ps
module gp_port_bench;
  import gp_pkg::*;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [GP_ADDR_W-1:0] paddr;
  logic [GP_DATA_W-1:0] pwdata, prdata, rd;
  logic [GP_PINS-1:0]   pin_in, pin_out, pin_oe_n, pullup_en, ext_drv, ext_en;
  int                   bad_count, total_checks;
  logic                 pready_a, pslverr_a, irq_a, err_a, rdy_a;
  logic [GP_DATA_W-1:0] prdata_a, rd_a;
  logic [GP_PINS-1:0]   pins_a, pin_out_a, pin_oe_n_a, pullup_en_a;

  gp_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_en(pullup_en), .irq(irq));
  gp_pin_model i_pins (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_en(pullup_en),
    .ext_drv(ext_drv), .ext_en(ext_en), .pin_lvl(pin_in));
  // Six-interrupt variant shares the bus; its pins come straight from the bench
  gp_port #(.VARIANT(GP_TYPE_A)) i_dut_a (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_a),
    .pready(pready_a), .pslverr(pslverr_a), .pin_in(pins_a), .pin_out(pin_out_a),
    .pin_oe_n(pin_oe_n_a), .pullup_en(pullup_en_a), .irq(irq_a));

  // Clock, 100 ns period
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [GP_ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      bad_count++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    rd_a = prdata_a;
    err_a = pslverr_a;
    rdy_a = pready_a;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next setup never reassigns psel in this time step
    @(posedge pclk);
  endtask : apb

  task automatic rchk(input logic [GP_ADDR_W-1:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, {24'h0, exp});
  endtask : rchk

  // Waits a bounded time for irq to reach a level
  task automatic wait_irq(input logic lvl);
    for (int n = 0; n < 10 && irq !== lvl; n++)
      @(posedge pclk);
    check({31'h0, irq}, {31'h0, lvl});
  endtask : wait_irq

  task automatic t_reset;
    rchk(GP_OFF_OUT, 8'hff);
    check(rd_a, 32'h00);
    check({24'h0, pin_oe_n_a}, 32'hff);
    rchk(GP_OFF_DIR, 8'h00);
    rchk(GP_OFF_IEN, 8'h00);
    rchk(GP_OFF_IFLAG, 8'h00);
    rchk(GP_OFF_IEDGE, 8'h00);
    check({24'h0, pin_oe_n}, 32'hff);
    check({24'h0, pullup_en}, 32'hff);
    $display("reset values done");
  endtask : t_reset

  // Mixed directions, pull-ups and live input readback
  task automatic t_drive;
    apb(1'b1, GP_OFF_DIR, 32'h0f);
    apb(1'b1, GP_OFF_OUT, 32'ha5);
    ext_en <= 8'h50;
    ext_drv <= 8'h40;
    check({24'h0, pin_oe_n}, 32'hf0);
    check({24'h0, pullup_en}, 32'ha0);
    check({24'h0, pin_out}, 32'ha5);
    check({24'h0, pin_oe_n_a}, 32'hf0);
    check({24'h0, pullup_en_a}, 32'h00);
    rchk(GP_OFF_IN, 8'he5);
    apb(1'b1, GP_OFF_DIR, 32'h00);
    rchk(GP_OFF_OUT, 8'ha5);
    check({24'h0, pin_oe_n}, 32'hff);
    ext_en <= 8'hff;
    ext_drv <= 8'h00;
    apb(1'b1, GP_OFF_IFLAG, 32'h0);
    $display("pin drive done");
  endtask : t_drive

  // Edges, polarity, sticky flags, masking and software set
  task automatic t_irq;
    apb(1'b1, GP_OFF_IFLAG, 32'h0);
    apb(1'b1, GP_OFF_IEN, 32'h01);
    ext_drv <= 8'h01;
    wait_irq(1'b1);
    ext_drv <= 8'h00;
    rchk(GP_OFF_IFLAG, 8'h01);
    apb(1'b1, GP_OFF_IFLAG, 32'h0);
    wait_irq(1'b0);
    apb(1'b1, GP_OFF_IEDGE, 32'h01);
    ext_drv <= 8'h01;
    repeat (6) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    ext_drv <= 8'h00;
    wait_irq(1'b1);
    apb(1'b1, GP_OFF_IEN, 32'h00);
    wait_irq(1'b0);
    ext_drv <= 8'h02;
    repeat (6) @(posedge pclk);
    rchk(GP_OFF_IFLAG, 8'h03);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, GP_OFF_IEN, 32'h02);
    wait_irq(1'b1);
    apb(1'b1, GP_OFF_IFLAG, 32'h0);
    apb(1'b1, GP_OFF_IEN, 32'h80);
    apb(1'b1, GP_OFF_IFLAG, 32'h80);
    wait_irq(1'b1);
    apb(1'b1, GP_OFF_IFLAG, 32'h0);
    wait_irq(1'b0);
    $display("interrupts done");
  endtask : t_irq

  // Six-interrupt variant: group polarity, enables and reserved flags
  task automatic t_six;
    apb(1'b1, GP_OFF_IFLAG, 32'h0);
    apb(1'b1, GP_OFF_IEN, 32'h44);
    pins_a <= 8'h07;
    repeat (6) @(posedge pclk);
    check({31'h0, irq_a}, 32'h1);
    apb(1'b0, GP_OFF_IFLAG, 32'h0);
    check(rd_a, 32'h04);
    pins_a <= 8'hc0;
    repeat (6) @(posedge pclk);
    apb(1'b0, GP_OFF_IFLAG, 32'h0);
    check(rd_a, 32'h07);
    apb(1'b1, GP_OFF_IEN, 32'h00);
    apb(1'b1, GP_OFF_IFLAG, 32'hff);
    apb(1'b0, GP_OFF_IFLAG, 32'h0);
    check(rd_a, 32'h3f);
    check({31'h0, irq_a}, 32'h0);
    apb(1'b1, GP_OFF_IFLAG, 32'h0);
    $display("six-irq variant done");
  endtask : t_six

  // Unmapped address and read-only register
  task automatic t_err;
    apb(1'b0, 8'h18, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, GP_OFF_IN, 32'h33);
    check({31'h0, err}, 32'h0);
    apb(1'b0, GP_OFF_IEDGE, 32'h0);
    check({30'h0, err, err_a}, 32'h1);
    check({31'h0, rdy_a}, 32'h1);
    $display("bus errors done");
  endtask : t_err

  // Main sequence
  initial
  begin
    bad_count = 0;
    total_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_drv = 8'h00;
    ext_en = 8'hff;
    pins_a = 8'h00;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_drive();
    t_irq();
    t_six();
    t_err();
    wrap_up();
  end
endmodule : gp_port_bench
